// [pcd_regs.v]
// Purpose: PHY cable-diagnostic and special register bank, two PHYs
// Assumes: MIIM and switch-host accesses are one-cycle strobes
// Notes: 8-bit region decode is reported for the rest of the switch
`timescale 1ns/1ps
`include "pcd_consts.vh"

module pcd_regs (
    input wire i_clock,
    input wire i_rst_n,
    // MII management side, 16-bit registers
    input wire [4:0] i_phy_select,
    input wire [4:0] i_phy_register_select,
    input wire i_miim_wr_en,
    input wire i_miim_rd_en,
    input wire [15:0] i_miim_wdata,
    output reg [15:0] o_miim_rdata,
    output reg o_miim_hit,
    // switch host side, 8-bit registers
    input wire [7:0] i_sw_addr,
    input wire i_sw_wr_en,
    input wire i_sw_rd_en,
    input wire [7:0] i_sw_wdata,
    output reg [7:0] o_sw_rdata,
    output reg o_sw_hit,
    output reg [3:0] o_sw_region,
    // per-PHY status from the analog side, index 0 is PHY1
    input wire [1:0] i_test_done,
    input wire [3:0] i_test_result,
    input wire [1:0] i_near_short_flag,
    input wire [17:0] i_fault_count,
    input wire [1:0] i_polarity_reversed,
    input wire [1:0] i_mdi_straight,
    // per-PHY controls
    output wire [1:0] o_test_enable,
    output wire [1:0] o_force_link,
    output wire [1:0] o_power_save_en,
    output wire [1:0] o_remote_loopback
);
    wire [31:0] diag_words;
    wire [31:0] spec_words;
    wire [1:0] phy_hit;
    wire miim_is_diag;
    wire miim_is_spec;
    wire [7:0] sw_ctrl_addr [0:1];
    wire [7:0] sw_count_addr [0:1];
    wire [7:0] sw_stat0_addr [0:1];
    wire [7:0] sw_stat1_addr [0:1];
    reg [15:0] miim_rdata_next;
    reg miim_hit_next;
    reg [7:0] sw_rdata_next;
    reg sw_hit_next;
    reg [3:0] region_next;
    integer k;

    assign phy_hit[0] = (i_phy_select == `PCD_PHY1_ADDR);
    assign phy_hit[1] = (i_phy_select == `PCD_PHY2_ADDR);
    assign miim_is_diag = (i_phy_register_select == `PCD_REG_DIAG);
    assign miim_is_spec = (i_phy_register_select == `PCD_REG_SPECIAL);

    assign sw_ctrl_addr[0] = `PCD_SW_P1_CTRL;
    assign sw_ctrl_addr[1] = `PCD_SW_P2_CTRL;
    assign sw_count_addr[0] = `PCD_SW_P1_COUNT;
    assign sw_count_addr[1] = `PCD_SW_P2_COUNT;
    assign sw_stat0_addr[0] = `PCD_SW_P1_STAT0;
    assign sw_stat0_addr[1] = `PCD_SW_P2_STAT0;
    assign sw_stat1_addr[0] = `PCD_SW_P1_STAT1;
    assign sw_stat1_addr[1] = `PCD_SW_P2_STAT1;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : phy
            pcd_phy_slice u_slice (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                // [RL18] only writable fields take write data
                .i_wr_diag16(i_miim_wr_en && phy_hit[g] && miim_is_diag),
                .i_wr_spec16(i_miim_wr_en && phy_hit[g] && miim_is_spec),
                .i_wdata16(i_miim_wdata),
                .i_wr_ctrl8(i_sw_wr_en && (i_sw_addr == sw_ctrl_addr[g])),
                .i_wdata8(i_sw_wdata),
                .i_test_done(i_test_done[g]),
                .i_test_result(i_test_result[2*g+1:2*g]),
                .i_near_short(i_near_short_flag[g]),
                .i_fault_count(i_fault_count[9*g+8:9*g]),
                .i_polarity_reversed(i_polarity_reversed[g]),
                .i_mdi_straight(i_mdi_straight[g]),
                .o_diag_word(diag_words[16*g+15:16*g]),
                .o_spec_word(spec_words[16*g+15:16*g]),
                .o_test_enable(o_test_enable[g]),
                .o_force_link(o_force_link[g]),
                .o_power_save_en(o_power_save_en[g]),
                .o_remote_loopback(o_remote_loopback[g])
            );
        end
    endgenerate

    // 16-bit read; unmapped reads return zero
    always @* begin
        miim_rdata_next = 16'h0000;
        miim_hit_next = 1'b0;
        for (k = 0; k < 2; k = k + 1) begin
            if (phy_hit[k] && miim_is_diag) begin
                miim_rdata_next = diag_words[16*k +: 16];
                miim_hit_next = 1'b1;
            end else if (phy_hit[k] && miim_is_spec) begin
                miim_rdata_next = spec_words[16*k +: 16];
                miim_hit_next = 1'b1;
            end
        end
    end

    // 8-bit mirrors; bits owned by other blocks read zero here
    always @* begin
        sw_rdata_next = 8'h00;
        sw_hit_next = 1'b0;
        for (k = 0; k < 2; k = k + 1) begin
            if (i_sw_addr == sw_ctrl_addr[k]) begin
                // [RL12] [RL13] short, result, control, count msb
                sw_rdata_next = {
                    diag_words[16*k + `PCD_DIAG_SHORT_BIT],
                    diag_words[16*k + `PCD_DIAG_RESULT_HI],
                    diag_words[16*k + `PCD_DIAG_RESULT_LO],
                    diag_words[16*k + `PCD_DIAG_ENABLE_BIT],
                    spec_words[16*k + `PCD_SPEC_FORCE_BIT],
                    spec_words[16*k + `PCD_SPEC_PWRSAVE_BIT],
                    spec_words[16*k + `PCD_SPEC_LOOPBACK_BIT],
                    diag_words[16*k + `PCD_DIAG_COUNT_HI]};
                sw_hit_next = 1'b1;
            end else if (i_sw_addr == sw_count_addr[k]) begin
                // [RL13] low count byte
                sw_rdata_next = diag_words[16*k +: 8];
                sw_hit_next = 1'b1;
            end else if (i_sw_addr == sw_stat0_addr[k]) begin
                // [RL14] crossover mirror
                sw_rdata_next[`PCD_SW_MDI_BIT] =
                    spec_words[16*k + `PCD_SPEC_MDI_BIT];
                sw_hit_next = 1'b1;
            end else if (i_sw_addr == sw_stat1_addr[k]) begin
                // [RL14] polarity mirror
                sw_rdata_next[`PCD_SW_POLARITY_BIT] =
                    spec_words[16*k + `PCD_SPEC_POLARITY_BIT];
                sw_hit_next = 1'b1;
            end
        end
    end

    // [RL15] [RL16] [RL17] top-level 8-bit region decode
    always @* begin
        if (i_sw_addr <= `PCD_ID_LAST)
            region_next = `PCD_REGION_ID;
        else if (i_sw_addr <= `PCD_GLOBAL_LAST)
            region_next = `PCD_REGION_GLOBAL;
        else if (i_sw_addr <= `PCD_P1_CTRL_LAST)
            region_next = `PCD_REGION_P1_CTRL;
        else if (i_sw_addr <= `PCD_P1_STAT_LAST)
            region_next = `PCD_REGION_P1_STAT;
        else if (i_sw_addr <= `PCD_P2_CTRL_LAST)
            region_next = `PCD_REGION_P2_CTRL;
        else if (i_sw_addr <= `PCD_P2_STAT_LAST)
            region_next = `PCD_REGION_P2_STAT;
        else if (i_sw_addr <= `PCD_P3_CTRL_LAST)
            region_next = `PCD_REGION_P3_CTRL;
        else if (i_sw_addr <= `PCD_RSVD_LAST)
            region_next = `PCD_REGION_RSVD;
        else if (i_sw_addr == `PCD_P3_STAT)
            region_next = `PCD_REGION_P3_STAT;
        else
            region_next = `PCD_REGION_OTHER;
    end

    // read data held until the next read strobe
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_miim_rdata <= 16'h0000;
            o_miim_hit <= 1'b0;
            o_sw_rdata <= 8'h00;
            o_sw_hit <= 1'b0;
            o_sw_region <= `PCD_REGION_ID;
        end else begin
            if (i_miim_rd_en) begin
                o_miim_rdata <= miim_rdata_next;
                o_miim_hit <= miim_hit_next;
            end
            if (i_sw_rd_en || i_sw_wr_en) begin
                o_sw_region <= region_next;
            end
            if (i_sw_rd_en) begin
                o_sw_rdata <= sw_rdata_next;
                o_sw_hit <= sw_hit_next;
            end
        end
    end
endmodule

// [pcd_consts.vh]
// Purpose: constants for the PHY cable-diagnostic and special register bank
// Assumes: one 40 MHz clock, asynchronous active-low reset
// Notes: 16-bit PHY registers plus their 8-bit switch-space mirrors
//
// Overview of operation
// [RL1] writing one starts test, self-clears when done
// [RL2] bits 14:13 give cable test result code
// [RL3] bit 12 flags short within ten metres
// [RL4] bits 8:0 fault count, about 0.4 m each
// [RL5] diag 11:9 and special 15:6 read zero
// [RL6] bit 5 shows receive polarity reversed
// [RL7] bit 4 one means MDI, zero MDI-X
// [RL8] bit 3 forces link pass when set
// [RL9] bit 2 zero enables power saving, resets one
// [RL10] bit 1 loops received signal back to transmit
// [RL11] host leaves reserved bit 0 at zero
// [RL12] result code mirrored at reg 26/42 bits 6:5
// [RL13] count bit 8 in reg 26/42, rest 27/43
// [RL14] crossover in reg 30/46, polarity reg 31/47
// [RL15] decode port control ranges for three ports
// [RL16] decode port status ranges, 0x3A-0x3E reserved
// [RL17] identity 0x00-0x01, global control 0x02-0x0F
// [RL18] read-only writes ignored, both spaces agree
`ifndef PCD_CONSTS_VH
`define PCD_CONSTS_VH

// 16-bit PHY register space
`define PCD_PHY_SEL_W 5
`define PCD_PHY1_ADDR 5'h01
`define PCD_PHY2_ADDR 5'h02
`define PCD_REG_DIAG 5'h1D
`define PCD_REG_SPECIAL 5'h1F

// diagnostic register fields
`define PCD_DIAG_ENABLE_BIT 15
`define PCD_DIAG_RESULT_HI 14
`define PCD_DIAG_RESULT_LO 13
`define PCD_DIAG_SHORT_BIT 12
`define PCD_DIAG_COUNT_HI 8
`define PCD_RESULT_NORMAL 2'h0
`define PCD_RESULT_OPEN 2'h1
`define PCD_RESULT_SHORT 2'h2
`define PCD_RESULT_FAILED 2'h3
`define PCD_COUNT_RESET 9'h000
`define PCD_DECIMETRES_PER_COUNT 4

// special control/status fields
`define PCD_SPEC_POLARITY_BIT 5
`define PCD_SPEC_MDI_BIT 4
`define PCD_SPEC_FORCE_BIT 3
`define PCD_SPEC_PWRSAVE_BIT 2
`define PCD_SPEC_LOOPBACK_BIT 1
`define PCD_SPEC_RSVD_BIT 0
`define PCD_PWRSAVE_RESET 1'h1

// 8-bit mirror registers, PHY1 then PHY2
`define PCD_SW_P1_CTRL 8'h1A
`define PCD_SW_P1_COUNT 8'h1B
`define PCD_SW_P1_STAT0 8'h1E
`define PCD_SW_P1_STAT1 8'h1F
`define PCD_SW_P2_CTRL 8'h2A
`define PCD_SW_P2_COUNT 8'h2B
`define PCD_SW_P2_STAT0 8'h2E
`define PCD_SW_P2_STAT1 8'h2F
`define PCD_SW_SHORT_BIT 7
`define PCD_SW_RESULT_HI 6
`define PCD_SW_RESULT_LO 5
`define PCD_SW_ENABLE_BIT 4
`define PCD_SW_MDI_BIT 7
`define PCD_SW_POLARITY_BIT 5

// 8-bit region bounds
`define PCD_ID_LAST 8'h01
`define PCD_GLOBAL_LAST 8'h0F
`define PCD_P1_CTRL_LAST 8'h1D
`define PCD_P1_STAT_LAST 8'h1F
`define PCD_P2_CTRL_LAST 8'h2D
`define PCD_P2_STAT_LAST 8'h2F
`define PCD_P3_CTRL_LAST 8'h39
`define PCD_RSVD_LAST 8'h3E
`define PCD_P3_STAT 8'h3F

// region codes
`define PCD_REGION_W 4
`define PCD_REGION_ID 4'h0
`define PCD_REGION_GLOBAL 4'h1
`define PCD_REGION_P1_CTRL 4'h2
`define PCD_REGION_P1_STAT 4'h3
`define PCD_REGION_P2_CTRL 4'h4
`define PCD_REGION_P2_STAT 4'h5
`define PCD_REGION_P3_CTRL 4'h6
`define PCD_REGION_RSVD 4'h7
`define PCD_REGION_P3_STAT 4'h8
`define PCD_REGION_OTHER 4'h9

`endif

// [pcd_phy_slice.v]
// Purpose: per-PHY diagnostic and special control/status state
// Assumes: write strobes are one-cycle pulses, already decoded
// Notes: one copy per copper PHY, shared by both address spaces
`timescale 1ns/1ps
`include "pcd_consts.vh"

module pcd_phy_slice (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_wr_diag16,
    input wire i_wr_spec16,
    input wire [15:0] i_wdata16,
    input wire i_wr_ctrl8,
    input wire [7:0] i_wdata8,
    input wire i_test_done,
    input wire [1:0] i_test_result,
    input wire i_near_short,
    input wire [8:0] i_fault_count,
    input wire i_polarity_reversed,
    input wire i_mdi_straight,
    output wire [15:0] o_diag_word,
    output wire [15:0] o_spec_word,
    output wire o_test_enable,
    output wire o_force_link,
    output wire o_power_save_en,
    output wire o_remote_loopback
);
    reg enable_reg;
    reg [1:0] result_reg;
    reg short_reg;
    reg [8:0] count_reg;
    reg force_reg;
    reg pwrsave_off_reg;
    reg loop_reg;
    reg rsvd0_reg;
    reg polarity_reg;
    reg mdi_reg;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_reg <= 1'b0;
            result_reg <= `PCD_RESULT_NORMAL;
            short_reg <= 1'b0;
            count_reg <= `PCD_COUNT_RESET;
            force_reg <= 1'b0;
            pwrsave_off_reg <= `PCD_PWRSAVE_RESET;
            loop_reg <= 1'b0;
            rsvd0_reg <= 1'b0;
            polarity_reg <= 1'b0;
            mdi_reg <= 1'b0;
        end else begin
            // [RL6] [RL7] live status sampled
            polarity_reg <= i_polarity_reversed;
            mdi_reg <= i_mdi_straight;
            // [RL2] [RL3] [RL4] capture test outcome
            if (enable_reg && i_test_done) begin
                result_reg <= i_test_result;
                short_reg <= i_near_short;
                count_reg <= i_fault_count;
            end
            // [RL1] host write wins over self-clear
            if (i_wr_diag16)
                enable_reg <= i_wdata16[`PCD_DIAG_ENABLE_BIT];
            else if (i_wr_ctrl8)
                enable_reg <= i_wdata8[`PCD_SW_ENABLE_BIT];
            else if (i_test_done)
                enable_reg <= 1'b0;
            // [RL8] [RL9] [RL10] control bits, either space
            if (i_wr_spec16) begin
                force_reg <= i_wdata16[`PCD_SPEC_FORCE_BIT];
                pwrsave_off_reg <= i_wdata16[`PCD_SPEC_PWRSAVE_BIT];
                loop_reg <= i_wdata16[`PCD_SPEC_LOOPBACK_BIT];
                rsvd0_reg <= i_wdata16[`PCD_SPEC_RSVD_BIT];
            end else if (i_wr_ctrl8) begin
                force_reg <= i_wdata8[`PCD_SPEC_FORCE_BIT];
                pwrsave_off_reg <= i_wdata8[`PCD_SPEC_PWRSAVE_BIT];
                loop_reg <= i_wdata8[`PCD_SPEC_LOOPBACK_BIT];
            end
        end
    end

    // [RL5] diag 11:9 and special 15:6 read zero; reserved bit 0 reads back as written
    assign o_diag_word = {enable_reg, result_reg, short_reg, 3'h0,
                          count_reg};
    assign o_spec_word = {10'h000, polarity_reg, mdi_reg, force_reg,
                          pwrsave_off_reg, loop_reg, rsvd0_reg};
    assign o_test_enable = enable_reg;
    assign o_force_link = force_reg;
    // [RL9] inverted sense
    assign o_power_save_en = ~pwrsave_off_reg;
    assign o_remote_loopback = loop_reg;
endmodule

// [pcd_regs_chk.sv]
// Purpose: port checker for the cable-diagnostic register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to pcd_regs by bind
`timescale 1ns/1ps
module pcd_regs_chk (
    input wire i_clock,
    input wire i_rst_n,
    input wire [4:0] i_phy_select,
    input wire [4:0] i_phy_register_select,
    input wire i_miim_wr_en,
    input wire i_miim_rd_en,
    input wire [15:0] i_miim_wdata,
    input wire [15:0] o_miim_rdata,
    input wire o_miim_hit,
    input wire [7:0] i_sw_addr,
    input wire i_sw_wr_en,
    input wire i_sw_rd_en,
    input wire [3:0] o_sw_region,
    input wire [1:0] i_test_done,
    input wire [1:0] o_test_enable,
    input wire [1:0] o_force_link,
    input wire [1:0] o_power_save_en,
    input wire [1:0] o_remote_loopback
);
    wire wr1 = i_miim_wr_en && i_phy_select == 5'h01;
    wire wr2 = i_miim_wr_en && i_phy_select == 5'h02;
    wire spec1 = wr1 && i_phy_register_select == 5'h1F;
    wire spec2 = wr2 && i_phy_register_select == 5'h1F;
    wire diag1 = wr1 && i_phy_register_select == 5'h1D;
    wire sw1 = i_sw_wr_en && i_sw_addr == 8'h1A;
    wire sw_any = i_sw_rd_en || i_sw_wr_en;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    chk_pwrsave_inverted: assert property (
        spec1 |=> o_power_save_en[0] == !$past(i_miim_wdata[2]))
        else $error("power save enable not inverse of written bit");
    chk_force_link_wr: assert property (
        spec2 |=> o_force_link[1] == $past(i_miim_wdata[3]))
        else $error("force link does not follow write");
    chk_loopback_wr: assert property (
        spec2 |=> o_remote_loopback[1] == $past(i_miim_wdata[1]))
        else $error("loopback does not follow write");
    chk_test_start: assert property (
        diag1 && i_miim_wdata[15] |=> o_test_enable[0])
        else $error("test enable not set by write");
    chk_test_selfclear: assert property (
        o_test_enable[0] && i_test_done[0] && !diag1 && !sw1
        |=> !o_test_enable[0])
        else $error("test enable not cleared on completion");
    chk_unmapped_read: assert property (
        i_miim_rd_en && (i_phy_select == 5'h00 || i_phy_select > 5'h02)
        |=> !o_miim_hit && o_miim_rdata == 16'h0000)
        else $error("unmapped read not zero without hit");
    chk_region_reserved: assert property (
        sw_any && i_sw_addr >= 8'h3A && i_sw_addr <= 8'h3E
        |=> o_sw_region == 4'h7)
        else $error("reserved range region code wrong");
    chk_special_zeros: assert property (
        i_miim_rd_en && i_phy_select == 5'h01 && i_phy_register_select
        == 5'h1F |=> o_miim_hit && o_miim_rdata[15:6] == 10'h000)
        else $error("special register upper bits not zero");
endmodule
bind pcd_regs pcd_regs_chk pcd_regs_chk_i (.*);

// [pcd_host_model.sv]
// Purpose: management host for both register spaces
// Assumes: tasks are entered just after a rising edge
// Notes: strobes last one cycle, fields held through the edge
`timescale 1ns/1ps
module pcd_host_model (
    input wire i_clock,
    output reg [4:0] o_phy_select,
    output reg [4:0] o_phy_register_select,
    output reg o_miim_wr_en,
    output reg o_miim_rd_en,
    output reg [15:0] o_miim_wdata,
    output reg [7:0] o_sw_addr,
    output reg o_sw_wr_en,
    output reg o_sw_rd_en,
    output reg [7:0] o_sw_wdata,
    input wire [15:0] i_miim_rdata,
    input wire [7:0] i_sw_rdata
);
    initial begin
        o_phy_select = 5'h00;
        o_phy_register_select = 5'h00;
        o_miim_wr_en = 1'b0;
        o_miim_rd_en = 1'b0;
        o_miim_wdata = 16'h0000;
        o_sw_addr = 8'h00;
        o_sw_wr_en = 1'b0;
        o_sw_rd_en = 1'b0;
        o_sw_wdata = 8'h00;
    end
    task mio(input wr, input [4:0] p, input [4:0] r, input [15:0] d,
        output [15:0] q);
        begin
            o_phy_select = p;
            o_phy_register_select = r;
            o_miim_wdata = (r == 5'h1F) ? {d[15:1], 1'b0} : d;
            o_miim_wr_en = wr;
            o_miim_rd_en = !wr;
            @(posedge i_clock);
            #1;
            o_miim_wr_en = 1'b0;
            o_miim_rd_en = 1'b0;
            q = i_miim_rdata;
        end
    endtask
    task sio(input wr, input [7:0] a, input [7:0] d, output [7:0] q);
        begin
            o_sw_addr = a;
            o_sw_wdata = d;
            o_sw_wr_en = wr;
            o_sw_rd_en = !wr;
            @(posedge i_clock);
            #1;
            o_sw_wr_en = 1'b0;
            o_sw_rd_en = 1'b0;
            q = i_sw_rdata;
        end
    endtask
endmodule

// [pcd_regs_tb_top.sv]
// Purpose: self-checking bench for the cable-diagnostic register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: status inputs are sampled, so reads wait a cycle
`timescale 1ns/1ps
module pcd_regs_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [1:0] done = 2'b00, shrt = 2'b00, pol = 2'b00, mdi = 2'b00;
    reg [3:0] res = 4'h0;
    reg [17:0] cnt = 18'h00000;
    reg [15:0] q;
    reg [7:0] b;
    integer bad_count = 0, n_tests = 0, i;
    wire [4:0] sel, rsel;
    wire mwe, mre, swe, sre, mhit, shit;
    wire [15:0] mwd, mrd;
    wire [7:0] sa, swd, srd;
    wire [3:0] region;
    wire [1:0] ten, fl, pe, lb;
    always #12.5 clk = ~clk;
    pcd_host_model pcd_host_model_i (.i_clock(clk), .o_phy_select(sel),
        .o_phy_register_select(rsel), .o_miim_wr_en(mwe),
        .o_miim_rd_en(mre), .o_miim_wdata(mwd), .o_sw_addr(sa),
        .o_sw_wr_en(swe), .o_sw_rd_en(sre), .o_sw_wdata(swd),
        .i_miim_rdata(mrd), .i_sw_rdata(srd));
    pcd_regs pcd_regs_i (.i_clock(clk), .i_rst_n(rst_n),
        .i_phy_select(sel), .i_phy_register_select(rsel),
        .i_miim_wr_en(mwe), .i_miim_rd_en(mre), .i_miim_wdata(mwd),
        .o_miim_rdata(mrd), .o_miim_hit(mhit), .i_sw_addr(sa),
        .i_sw_wr_en(swe), .i_sw_rd_en(sre), .i_sw_wdata(swd),
        .o_sw_rdata(srd), .o_sw_hit(shit), .o_sw_region(region),
        .i_test_done(done), .i_test_result(res), .i_near_short_flag(shrt),
        .i_fault_count(cnt), .i_polarity_reversed(pol),
        .i_mdi_straight(mdi), .o_test_enable(ten), .o_force_link(fl),
        .o_power_save_en(pe), .o_remote_loopback(lb));
    task check(input [15:0] g, input [15:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                $display("wrong value at %0t: got %h expected %h",
                    $time, g, e);
                bad_count = bad_count + 1;
            end
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    function [3:0] exp_region(input [7:0] a);
        begin
            if (a <= 8'h01) exp_region = 4'h0;
            else if (a <= 8'h0F) exp_region = 4'h1;
            else if (a <= 8'h1D) exp_region = 4'h2;
            else if (a <= 8'h1F) exp_region = 4'h3;
            else if (a <= 8'h2D) exp_region = 4'h4;
            else if (a <= 8'h2F) exp_region = 4'h5;
            else if (a <= 8'h39) exp_region = 4'h6;
            else if (a <= 8'h3E) exp_region = 4'h7;
            else if (a == 8'h3F) exp_region = 4'h8;
            else exp_region = 4'h9;
        end
    endfunction
    task t_diag(input integer ph, input [1:0] code, input sh,
        input [8:0] c);
        reg [4:0] p;
        reg [7:0] a;
        begin
            p = ph ? 5'h02 : 5'h01;
            a = ph ? 8'h2A : 8'h1A;
            pcd_host_model_i.mio(1'b1, p, 5'h1D, 16'h8000, q);
            check(ten[ph], 1'b1);
            res[ph*2 +: 2] = code;
            shrt[ph] = sh;
            cnt[ph*9 +: 9] = c;
            done[ph] = 1'b1;
            @(posedge clk);
            #1;
            done[ph] = 1'b0;
            for (i = 0; i < 4 && ten[ph] !== 1'b0; i = i + 1) begin
                @(posedge clk);
                #1;
            end
            if (ten[ph] !== 1'b0) begin
                bad_count = bad_count + 1;
                conclude;
            end
            pcd_host_model_i.mio(1'b1, p, 5'h1D, 16'h7FFF, q);
            pcd_host_model_i.mio(1'b0, p, 5'h1D, 16'h0000, q);
            check(q, {1'b0, code, sh, 3'b000, c});
            pcd_host_model_i.sio(1'b0, a, 8'h00, b);
            check(b, {sh, code, 4'b0010, c[8]});
            check(shit, 1'b1);
            pcd_host_model_i.sio(1'b0, a + 8'h01, 8'h00, b);
            check(b, c[7:0]);
        end
    endtask
    task t_spec(input integer ph);
        reg [4:0] p;
        reg [7:0] a;
        begin
            p = ph ? 5'h02 : 5'h01;
            a = ph ? 8'h2A : 8'h1A;
            pol[ph] = 1'b1;
            mdi[ph] = 1'b1;
            pcd_host_model_i.mio(1'b1, p, 5'h1F, 16'hFFCA, q);
            pcd_host_model_i.mio(1'b0, p, 5'h1F, 16'h0000, q);
            check(q, 16'h003A);
            check({fl[ph], pe[ph], lb[ph]}, 3'b111);
            pcd_host_model_i.sio(1'b0, a + 8'h04, 8'h00, b);
            check(b[7], 1'b1);
            pcd_host_model_i.sio(1'b0, a + 8'h05, 8'h00, b);
            check(b[5], 1'b1);
            pcd_host_model_i.sio(1'b0, a, 8'h00, b);
            check(b[4:1], 4'b0101);
            pol[ph] = 1'b0;
            mdi[ph] = 1'b0;
            pcd_host_model_i.sio(1'b1, a, 8'h04, b);
            pcd_host_model_i.mio(1'b0, p, 5'h1F, 16'h0000, q);
            check(q, 16'h0004);
            check({fl[ph], pe[ph], lb[ph]}, 3'b000);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        pcd_host_model_i.mio(1'b0, 5'h01, 5'h1F, 16'h0000, q);
        check(q, 16'h0004);
        check(pe, 2'b00);
        pcd_host_model_i.mio(1'b0, 5'h02, 5'h1D, 16'h0000, q);
        check(q, 16'h0000);
        t_diag(0, 2'h0, 1'b0, 9'h000);
        t_diag(0, 2'h1, 1'b0, 9'h0FF);
        t_diag(0, 2'h2, 1'b1, 9'h100);
        t_diag(1, 2'h3, 1'b0, 9'h1FF);
        t_diag(1, 2'h2, 1'b1, 9'h155);
        t_spec(0);
        t_spec(1);
        for (i = 0; i <= 8'h41; i = i + 1) begin
            pcd_host_model_i.sio(1'b0, i[7:0], 8'h00, b);
            check(region, exp_region(i[7:0]));
            check(shit, (i[7:0] == 8'h1A || i[7:0] == 8'h1B || i[7:0] == 8'h1E || i[7:0] == 8'h1F || i[7:0] == 8'h2A || i[7:0] == 8'h2B || i[7:0] == 8'h2E || i[7:0] == 8'h2F));
        end
        pcd_host_model_i.sio(1'b1, 8'h3C, 8'hFF, b);
        check(region, 4'h7);
        pcd_host_model_i.mio(1'b0, 5'h03, 5'h1D, 16'h0000, q);
        check(q, 16'h0000);
        check(mhit, 1'b0);
        conclude;
    end
endmodule
